/* File: verilog/pcsd_cfg.svh */
// Register offsets, field positions, reset values and timing counts of the select decoder
`ifndef PCSD_CFG_SVH
`define PCSD_CFG_SVH
`define PCSD_OFS_CTRL1 16'hEF00
`define PCSD_OFS_CTRL2 16'hEF01
`define PCSD_OFS_TYPE 16'hEF03
`define PCSD_OFS_BASE 16'hEF04
`define PCSD_OFS_BASE_LAST 16'hEF23
`define PCSD_OFS_MASK 16'hEF24
`define PCSD_OFS_MASK_LAST 16'hEF43
`define PCSD_OFS_COMB 16'hEF45
`define PCSD_OFS_COMB_LAST 16'hEF4C
`define PCSD_OFS_TIME 16'hEF50
`define PCSD_OFS_TIME_LAST 16'hEF53
`define PCSD_RST_CTRL1 8'h02
`define PCSD_RST_CTRL2 8'h00
`define PCSD_BIT_ICD 0
`define PCSD_BIT_SHR 1
`define PCSD_BIT_RTC 4
`define PCSD_BIT_TMR 5
`define PCSD_BIT_GPE 2
`define PCSD_MASK_W 26
`define PCSD_BOOT_SEG 16'hFFFF
`define PCSD_MISS_WAITS 3'h7
`define PCSD_MISS_DELAY 1'b1
`endif

/* File: verilog/pcsd_pkg.sv */
// Types shared by the select decoder
package pcsd_pkg;
  typedef enum logic [2:0] {
    PCSD_IDLE = 3'b001,
    PCSD_DELAY = 3'b010,
    PCSD_ACCESS = 3'b100
  } pcsd_state_t;
endpackage

/* File: verilog/pcsd_top.sv */
// Programmable chip select decoder with access timing and bus control register
`timescale 1ns/1ns
`default_nettype none
`include "pcsd_cfg.svh"
module pcsd_top #(
  parameter int NSEL = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // CPU cycle
  input wire logic cyc_start,
  input wire logic [31:0] cyc_addr,
  input wire logic cyc_mem,
  input wire logic cyc_dram_hit,
  input wire logic cyc_periph_hit,
  input wire logic cyc_timer_hit,
  input wire logic cyc_rtc_hit,
  input wire logic cyc_shutdown,
  output logic cyc_done,
  // External bus
  input wire logic rdy,
  output logic [8:0] cs_n,
  output logic cmd_n,
  output logic ext_cycle,
  // Internal peripheral selects and CPU reset
  output logic timer_sel,
  output logic rtc_sel,
  output logic cpu_reset_req
);
  import pcsd_pkg::*;

  logic [7:0] ctrl1_ff;
  logic [7:0] ctrl2_ff;
  logic [NSEL-1:0] type_ff;
  logic [31:0] base_ff [NSEL];
  logic [`PCSD_MASK_W-1:0] mask_ff [NSEL];
  logic [NSEL-1:0] comb_ff [NSEL];
  logic [3:0] time_ff [NSEL];
  logic [NSEL-1:0] hit;
  logic [7:0] nxt_rdata;
  logic [15:0] rel;
  logic global_peripheral_gate;
  logic tmr_ok;
  logic rtc_ok;
  logic internal_hit;
  logic ext_now;
  logic boot_hit;
  logic [2:0] nxt_waits;
  logic nxt_delay;
  logic [8:0] nxt_cs_n;

  pcsd_state_t state_ff;
  logic [2:0] cnt_ff;
  logic rdy_s1_ff;
  logic rdy_s2_ff;
  logic [8:0] cs_n_ff;
  logic cmd_n_ff;
  logic ext_ff;
  logic done_ff;
  logic tsel_ff;
  logic rsel_ff;
  logic crst_ff;
  logic [7:0] rdata_ff;

  assign global_peripheral_gate = ctrl2_ff[`PCSD_BIT_GPE];
  assign tmr_ok = cyc_timer_hit & global_peripheral_gate & ctrl1_ff[`PCSD_BIT_TMR];
  assign rtc_ok = cyc_rtc_hit & global_peripheral_gate & ctrl1_ff[`PCSD_BIT_RTC];
  assign internal_hit = tmr_ok | rtc_ok | (cyc_periph_hit & global_peripheral_gate);
  // Debug mirroring runs the external cycle even when an internal target answers
  assign ext_now = ~cyc_dram_hit & (~internal_hit | ctrl1_ff[`PCSD_BIT_ICD]);
  assign boot_hit = cyc_mem & (cyc_addr[31:16] == `PCSD_BOOT_SEG);

  // Per-select address and type compare
  genvar g;
  generate
    for (g = 0; g < NSEL; g++) begin : g_sel
      assign hit[g] = (type_ff[g] == cyc_mem)
        & (cyc_addr[31:`PCSD_MASK_W] == base_ff[g][31:`PCSD_MASK_W])
        & (((cyc_addr[`PCSD_MASK_W-1:0] ^ base_ff[g][`PCSD_MASK_W-1:0])
            & ~mask_ff[g]) == '0);
      assign nxt_cs_n[g+1] = ~(|(comb_ff[g] & hit));
    end
  endgenerate
  assign nxt_cs_n[0] = ~boot_hit;

  // Timing of the lowest numbered hitting select wins; a miss takes the slowest timing
  always_comb begin
    nxt_waits = `PCSD_MISS_WAITS;
    nxt_delay = `PCSD_MISS_DELAY;
    for (int i = NSEL - 1; i >= 0; i--) begin
      if (hit[i]) begin
        nxt_waits = time_ff[i][2:0];
        nxt_delay = time_ff[i][3];
      end
    end
  end

  // Register writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl1_ff <= `PCSD_RST_CTRL1;
      ctrl2_ff <= `PCSD_RST_CTRL2;
      type_ff <= '0;
      for (int i = 0; i < NSEL; i++) begin
        base_ff[i] <= '0;
        mask_ff[i] <= '0;
        comb_ff[i] <= '0;
        time_ff[i] <= '0;
      end
    end else if (io_wr) begin
      if (io_addr == `PCSD_OFS_CTRL1) begin
        ctrl1_ff <= io_wdata;
      end
      if (io_addr == `PCSD_OFS_CTRL2) begin
        ctrl2_ff <= io_wdata & (8'h01 << `PCSD_BIT_GPE);
      end
      if (io_addr == `PCSD_OFS_TYPE) begin
        type_ff <= io_wdata[NSEL-1:0];
      end
      for (int i = 0; i < NSEL; i++) begin
        for (int b = 0; b < 4; b++) begin
          if (io_addr == 16'(`PCSD_OFS_BASE + 4 * i + b)) begin
            base_ff[i][8*b +: 8] <= io_wdata;
          end
          if (io_addr == 16'(`PCSD_OFS_MASK + 4 * i + b)) begin
            if (b == 3) begin
              mask_ff[i][25:24] <= io_wdata[1:0];
            end else begin
              mask_ff[i][8*b +: 8] <= io_wdata;
            end
          end
        end
        if (io_addr == 16'(`PCSD_OFS_COMB + i)) begin
          comb_ff[i] <= io_wdata[NSEL-1:0];
        end
        if (io_addr == 16'(`PCSD_OFS_TIME + i / 2)) begin
          time_ff[i] <= io_wdata[4*(i%2) +: 4];
        end
      end
    end
  end

  // Register read mux; unmapped addresses read zero
  always_comb begin
    nxt_rdata = 8'h00;
    rel = 16'h0000;
    if (io_addr == `PCSD_OFS_CTRL1) begin
      nxt_rdata = ctrl1_ff;
    end else if (io_addr == `PCSD_OFS_CTRL2) begin
      nxt_rdata = ctrl2_ff;
    end else if (io_addr == `PCSD_OFS_TYPE) begin
      nxt_rdata = 8'(type_ff);
    end else if (io_addr >= `PCSD_OFS_BASE && io_addr <= `PCSD_OFS_BASE_LAST) begin
      rel = io_addr - `PCSD_OFS_BASE;
      nxt_rdata = base_ff[rel[4:2]][8*rel[1:0] +: 8];
    end else if (io_addr >= `PCSD_OFS_MASK && io_addr <= `PCSD_OFS_MASK_LAST) begin
      rel = io_addr - `PCSD_OFS_MASK;
      nxt_rdata = 8'({6'h00, mask_ff[rel[4:2]]} >> (8 * rel[1:0]));
    end else if (io_addr >= `PCSD_OFS_COMB && io_addr <= `PCSD_OFS_COMB_LAST) begin
      rel = io_addr - `PCSD_OFS_COMB;
      nxt_rdata = 8'(comb_ff[rel[2:0]]);
    end else if (io_addr >= `PCSD_OFS_TIME && io_addr <= `PCSD_OFS_TIME_LAST) begin
      rel = io_addr - `PCSD_OFS_TIME;
      nxt_rdata = {time_ff[{rel[1:0], 1'b1}], time_ff[{rel[1:0], 1'b0}]};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 8'h00;
    end else if (io_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Ready comes from an external slave, so it is synchronised first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdy_s1_ff <= 1'b0;
      rdy_s2_ff <= 1'b0;
    end else begin
      rdy_s1_ff <= rdy;
      rdy_s2_ff <= rdy_s1_ff;
    end
  end

  // Cycle sequencer: optional command delay, then 1..8 access states plus ready extension
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= PCSD_IDLE;
      cnt_ff <= 3'h0;
      cs_n_ff <= 9'h1FF;
      cmd_n_ff <= 1'b1;
      ext_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        PCSD_IDLE: begin
          if (cyc_start) begin
            cs_n_ff <= nxt_cs_n;
            ext_ff <= ext_now;
            cnt_ff <= nxt_waits;
            if (nxt_delay) begin
              state_ff <= PCSD_DELAY;
            end else begin
              cmd_n_ff <= ~ext_now;
              state_ff <= PCSD_ACCESS;
            end
          end
        end
        PCSD_DELAY: begin
          cmd_n_ff <= ~ext_ff;
          state_ff <= PCSD_ACCESS;
        end
        PCSD_ACCESS: begin
          if (cnt_ff != 3'h0) begin
            cnt_ff <= cnt_ff - 3'h1;
          end else if (rdy_s2_ff) begin
            // Ready low at the last state keeps the cycle open until synchronised ready is sampled high
            state_ff <= PCSD_IDLE;
            cs_n_ff <= 9'h1FF;
            cmd_n_ff <= 1'b1;
            ext_ff <= 1'b0;
            done_ff <= 1'b1;
          end
        end
        default: begin
          state_ff <= PCSD_IDLE;
          cs_n_ff <= 9'h1FF;
          cmd_n_ff <= 1'b1;
          ext_ff <= 1'b0;
        end
      endcase
    end
  end

  // Internal peripheral selects and shutdown reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tsel_ff <= 1'b0;
      rsel_ff <= 1'b0;
      crst_ff <= 1'b0;
    end else begin
      crst_ff <= cyc_start & cyc_shutdown & ctrl1_ff[`PCSD_BIT_SHR];
      if (cyc_start && state_ff == PCSD_IDLE) begin
        tsel_ff <= tmr_ok;
        rsel_ff <= rtc_ok;
      end else if (done_ff) begin
        tsel_ff <= 1'b0;
        rsel_ff <= 1'b0;
      end
    end
  end

  assign io_rdata = rdata_ff;
  assign cs_n = cs_n_ff;
  assign cmd_n = cmd_n_ff;
  assign ext_cycle = ext_ff;
  assign cyc_done = done_ff;
  assign timer_sel = tsel_ff;
  assign rtc_sel = rsel_ff;
  assign cpu_reset_req = crst_ff;
endmodule // pcsd_top
`default_nettype wire

/* File: tb/pcsd_asserts.sv */
// Port checker for the select decoder
`timescale 1ns/1ns
`default_nettype none
module pcsd_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register writes
  input wire logic io_wr,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  // CPU cycle
  input wire logic cyc_start,
  input wire logic [31:0] cyc_addr,
  input wire logic cyc_mem,
  input wire logic cyc_dram_hit,
  input wire logic cyc_timer_hit,
  input wire logic cyc_shutdown,
  input wire logic cyc_done,
  // Outputs
  input wire logic [8:0] cs_n,
  input wire logic cmd_n,
  input wire logic ext_cycle,
  input wire logic timer_sel,
  input wire logic cpu_reset_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic bsy_ff, tmr_ff, gpe_ff, shr_ff;
  // A start in the done cycle is taken, so busy is judged with done
  wire acc = cyc_start && (!bsy_ff || cyc_done);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) bsy_ff <= 1'b0;
    else if (acc) bsy_ff <= 1'b1;
    else if (cyc_done) bsy_ff <= 1'b0;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) {tmr_ff, gpe_ff, shr_ff} <= 3'h1;
    else if (io_wr && io_addr == 16'hEF00) {tmr_ff, shr_ff} <= {io_wdata[5], io_wdata[1]};
    else if (io_wr && io_addr == 16'hEF01) gpe_ff <= io_wdata[2];
  end
  boot_cs_a: assert property (acc && cyc_mem && &cyc_addr[31:16] |=> !cs_n[0]) else $error("boot select missing");
  dram_quiet_a: assert property (acc && cyc_dram_hit |=> cmd_n && !ext_cycle) else $error("strobe on DRAM hit");
  cmd_inside_a: assert property (!cmd_n |-> ext_cycle && bsy_ff) else $error("strobe outside cycle");
  done_bound_a: assert property (acc |-> ##[2:40] cyc_done) else $error("cycle never ends");
  min_state_a: assert property (acc |=> !cyc_done) else $error("cycle without access state");
  idle_quiet_a: assert property (!bsy_ff |-> &cs_n && cmd_n) else $error("select while idle");
  timer_gate_a: assert property (acc && cyc_timer_hit |=> timer_sel == (tmr_ff && gpe_ff)) else $error("timer gate");
  shut_rst_a: assert property (cyc_start && cyc_shutdown |=> cpu_reset_req == shr_ff) else $error("shutdown reset");
  cover property (acc && cyc_dram_hit);
  cover property (acc && cyc_timer_hit);
  cover property (cpu_reset_req);
endmodule // pcsd_asserts
bind pcsd_top pcsd_asserts u_chk (.clk(clk), .resetn(resetn), .io_wr(io_wr), .io_addr(io_addr),
  .io_wdata(io_wdata), .cyc_start(cyc_start), .cyc_addr(cyc_addr), .cyc_mem(cyc_mem),
  .cyc_dram_hit(cyc_dram_hit), .cyc_timer_hit(cyc_timer_hit), .cyc_shutdown(cyc_shutdown),
  .cyc_done(cyc_done), .cs_n(cs_n), .cmd_n(cmd_n), .ext_cycle(ext_cycle), .timer_sel(timer_sel),
  .cpu_reset_req(cpu_reset_req));
`default_nettype wire

/* File: tb/pcsd_slave.sv */
// Slow external slave that stretches cycles with ready
`timescale 1ns/1ns
`default_nettype none
module pcsd_slave (
  // Clock, reset and bus
  input wire logic clk,
  input wire logic resetn,
  input wire logic ext_cycle,
  // Stretch length set by the bench
  input wire logic [3:0] stall,
  output logic rdy
);
  logic [3:0] cnt_ff;
  logic ext_ff;
  // Pulled up: high whenever not stretching
  assign rdy = (cnt_ff == 4'h0);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) {cnt_ff, ext_ff} <= 5'h00;
    else begin
      ext_ff <= ext_cycle;
      if (ext_cycle && !ext_ff) cnt_ff <= stall;
      else if (cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
    end
  end
endmodule // pcsd_slave
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the select decoder
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct {int lat; int cmd; logic [12:0] o; bit slow;} pcsd_exp_t;
  logic clk = 0, resetn = 0, io_wr = 0, io_rd = 0, cyc_start = 0, cyc_mem = 0;
  logic [4:0] hit = 0;
  logic [15:0] io_addr = 0;
  logic [7:0] io_wdata = 0, io_rdata;
  logic [31:0] cyc_addr = 0, rnd = 59;
  logic [12:0] o_seen;
  logic [8:0] cs_n;
  logic [3:0] stall = 0;
  logic cyc_done, rdy, cmd_n, ext_cycle, timer_sel, rtc_sel, cpu_reset_req;
  int n_mismatch = 0, checks = 0, n = 0, cmd_at = 0;
  pcsd_exp_t q[$];
  pcsd_exp_t e;
  always #25 clk = ~clk;
  pcsd_top u_dut (.clk(clk), .resetn(resetn), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .cyc_start(cyc_start), .cyc_addr(cyc_addr), .cyc_mem(cyc_mem),
    .cyc_dram_hit(hit[0]), .cyc_periph_hit(hit[1]), .cyc_timer_hit(hit[2]), .cyc_rtc_hit(hit[3]),
    .cyc_shutdown(hit[4]), .cyc_done(cyc_done), .rdy(rdy), .cs_n(cs_n), .cmd_n(cmd_n),
    .ext_cycle(ext_cycle), .timer_sel(timer_sel), .rtc_sel(rtc_sel), .cpu_reset_req(cpu_reset_req));
  pcsd_slave u_slave (.clk(clk), .resetn(resetn), .ext_cycle(ext_cycle), .stall(stall), .rdy(rdy));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    {io_wr, io_addr, io_wdata} = {1'b1, a, d};
    @(negedge clk);
    io_wr = 0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    {io_rd, io_addr} = {1'b1, a};
    @(negedge clk);
    io_rd = 0;
    chk(io_rdata, d);
  endtask
  task automatic sel(input int i, input logic [31:0] b, input logic [31:0] m);
    for (int k = 0; k < 4; k++) begin
      wr(16'hEF04 + 16'(4 * i - 4 + k), b[8*k +: 8]);
      wr(16'hEF24 + 16'(4 * i - 4 + k), m[8*k +: 8]);
    end
  endtask
  task automatic cyc(input logic [31:0] a, input logic m, input logic [4:0] h, input logic [12:0] o,
    input int lat, input int cmd, input bit slow);
    q.push_back('{lat, cmd, o, slow});
    @(negedge clk);
    {cyc_start, cyc_addr, cyc_mem, hit} = {1'b1, a, m, h};
    @(negedge clk);
    {cyc_start, hit} = 6'h00;
    for (int k = 0; k < 80 && q.size() != 0; k++) @(negedge clk);
    // A cycle that never finishes must not slip through to the verdict
    if (q.size() != 0) begin
      n_mismatch++;
      q.delete();
    end
  endtask
  // Cycle results are taken from the settled values at each rising edge
  always @(posedge clk) begin
    n = cyc_start ? 0 : n + 1;
    if (n == 0) cmd_at = 0;
    if (n == 1) o_seen = {cpu_reset_req, ext_cycle, timer_sel, rtc_sel, cs_n};
    if (!cmd_n && cmd_at == 0) cmd_at = n;
    if (cyc_done && q.size() != 0) begin
      e = q.pop_front();
      chk(o_seen, e.o);
      if (e.lat != 0) begin
        chk(e.slow ? 32'(n > e.lat) : 32'(n), e.slow ? 1 : e.lat);
        chk(cmd_at, e.cmd);
      end
    end
  end
  initial begin
    #200000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    resetn = 1;
    rd(16'hEF00, 8'h02);
    rd(16'hEF44, 8'h00);
    wr(16'hEF27, 8'hFF);
    rd(16'hEF27, 8'h03);
    wr(16'hEF03, 8'h06);
    rd(16'hEF03, 8'h06);
    sel(1, 32'h70, 32'h1);
    sel(2, 32'h1234_5678, 32'h0);
    sel(3, 32'h0, 32'h03FF_FFFF);
    wr(16'hEF45, 8'h01);
    wr(16'hEF46, 8'h03);
    wr(16'hEF47, 8'h06);
    wr(16'hEF50, 8'hB0);
    wr(16'hEF51, 8'h05);
    cyc(32'h71, 0, 5'h00, 13'h09F9, 2, 1, 0);
    cyc(32'h72, 0, 5'h00, 13'h09FF, 10, 2, 0);
    cyc(32'h70, 1, 5'h00, 13'h09F7, 7, 1, 0);
    cyc(32'h1234_5678, 1, 5'h00, 13'h09F3, 6, 2, 0);
    cyc(32'h1234_5679, 1, 5'h00, 13'h09FF, 10, 2, 0);
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      cyc(rnd & 32'h03FF_FFFF, 1, 5'h00, 13'h09F7, 7, 1, 0);
      cyc(rnd | 32'h0400_0000, 1, 5'h00, 13'h09FF, 10, 2, 0);
    end
    cyc(32'hFFFF_8000, 1, 5'h00, 13'h09FE, 10, 2, 0);
    cyc(32'h70, 0, 5'h01, 13'h01F9, 2, 0, 0);
    // With the global gate low a peripheral hit is an ordinary external cycle
    cyc(32'h70, 0, 5'h02, 13'h09F9, 2, 1, 0);
    cyc(32'h40, 0, 5'h0C, 13'h09FF, 10, 2, 0);
    wr(16'hEF00, 8'h30);
    cyc(32'h40, 0, 5'h1C, 13'h09FF, 10, 2, 0);
    wr(16'hEF01, 8'h04);
    cyc(32'h40, 0, 5'h04, 13'h05FF, 10, 0, 0);
    cyc(32'h40, 0, 5'h08, 13'h03FF, 10, 0, 0);
    cyc(32'h70, 0, 5'h02, 13'h01F9, 2, 0, 0);
    wr(16'hEF00, 8'h03);
    cyc(32'h70, 0, 5'h02, 13'h09F9, 2, 1, 0);
    cyc(32'h72, 0, 5'h10, 13'h19FF, 10, 2, 0);
    stall = 4'h4;
    cyc(32'h1234_5678, 1, 5'h00, 13'h09F3, 6, 2, 1);
    stall = 4'h0;
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
